// *** bench/pled_panel_model.sv ***
// Front panel buttons and remote contact.
// Assumes callers stay on the bench clock.
`timescale 1ns/1ps
module pled_panel_model (
   input wire logic ref_clk_i,
   output logic test_btn_o,
   output logic remote_test_o,
   output logic set_exer_btn_o
);
   initial begin
      {test_btn_o, remote_test_o, set_exer_btn_o} = 3'h0;
   end
   // Button levels change just after an edge
   task automatic push(input int which, input logic v);
      @(posedge ref_clk_i);
      #1;
      case (which)
         0: test_btn_o = v;
         1: remote_test_o = v;
         default: set_exer_btn_o = v;
      endcase
   endtask
endmodule

// *** bench/pled_status_monitor.sv ***
// Port checks for the lamp driver, bound into its top.
// Assumes lamps lag their inputs by one clock.
`timescale 1ns/1ps
module pled_status_monitor (
   // Clock, reset, inputs
   input wire logic ref_clk_i, rst_i, util_ok_i, gen_volt_ok_i, gen_freq_ok_i,
   input wire logic util_conn_i, util_conn_fail_i, gen_conn_i, gen_conn_fail_i,
   input wire logic exer_enable_i, exer_sched_i, exer_int_active_i, ext_exer_cfg_i,
   input wire logic ext_exer_i, set_exer_btn_i,
   // Lamps and status
   input wire logic util_avail_lamp_o, util_conn_lamp_o, gen_avail_lamp_o,
   input wire logic gen_conn_lamp_o, exer_lamp_o, test_lamp_o, test_active_o
);
   logic live_r;
   // First edge after reset still shows dark lamps
   always_ff @(posedge ref_clk_i) begin
      live_r <= !rst_i;
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // Lamp relations
   // ----------------------------------------
   a_util_avail_follow: assert property (live_r |-> util_avail_lamp_o == $past(util_ok_i))
      else $error("util avail lamp wrong");
   a_util_conn_steady: assert property (live_r && $past(util_conn_i && !util_conn_fail_i)
      |-> util_conn_lamp_o) else $error("util conn lamp dark");
   a_gen_avail_both: assert property (live_r
      |-> gen_avail_lamp_o == $past(gen_volt_ok_i && gen_freq_ok_i)) else $error("gen avail");
   a_gen_conn_off: assert property (live_r && $past(!gen_conn_i && !gen_conn_fail_i)
      |-> !gen_conn_lamp_o) else $error("gen conn lamp lit");
   a_exer_gate_off: assert property (live_r && !$past(exer_enable_i) |-> !exer_lamp_o)
      else $error("exercise lamp lit while disabled");
   a_exer_sched_on: assert property (live_r && $past(exer_enable_i && exer_sched_i
      && !set_exer_btn_i && !exer_int_active_i && !(ext_exer_cfg_i && ext_exer_i))
      |-> exer_lamp_o) else $error("exercise lamp not steady");
   a_ext_exer_gated: assert property (live_r && $past(exer_enable_i && !exer_sched_i
      && !set_exer_btn_i && !exer_int_active_i && !ext_exer_cfg_i)
      |-> !exer_lamp_o) else $error("external exercise not gated");
   a_test_run_lit: assert property (test_active_o && $past(test_active_o) |-> test_lamp_o)
      else $error("test lamp dark in test");
   a_test_power_loss: assert property (live_r && !$past(util_ok_i) |-> !test_active_o)
      else $error("test kept without power");
   c_test_run: cover property ($rose(test_active_o));
   c_test_end: cover property ($fell(test_active_o) && util_ok_i);
   c_exer_set: cover property (set_exer_btn_i && exer_enable_i ##4 exer_lamp_o);
endmodule
bind pled_status_driver pled_status_monitor u_mon (.*);

// *** bench/tb_top.sv ***
// Lamp driver bench; blink judged by toggle counts.
// Assumes short timing parameters.
`timescale 1ns/1ps
module tb_top;
   localparam int QC = 4;
   localparam int HOLD = 80;
   logic ref_clk_i, rst_i, util_ok_i, gen_volt_ok_i, gen_freq_ok_i, util_conn_i;
   logic util_conn_fail_i, gen_conn_i, gen_conn_fail_i, exer_enable_i, exer_sched_i;
   logic exer_int_active_i, ext_exer_cfg_i, ext_exer_i, set_exer_btn_i, test_btn_i;
   logic remote_test_i, util_avail_lamp_o, util_conn_lamp_o, gen_avail_lamp_o;
   logic gen_conn_lamp_o, exer_lamp_o, test_lamp_o, test_active_o;
   logic [5:0] lamps;
   logic [31:0] r;
   int n_errors, checks, cyc, n, i;
   int seed = 32'h7A4E;
   assign lamps = {test_lamp_o, exer_lamp_o, gen_conn_lamp_o, gen_avail_lamp_o,
                   util_conn_lamp_o, util_avail_lamp_o};
   pled_status_driver #(.QUARTER_CYC(QC), .TEST_HOLD_CYC(HOLD)) uut (.*);
   pled_panel_model pnl (.ref_clk_i(ref_clk_i), .test_btn_o(test_btn_i),
      .remote_test_o(remote_test_i), .set_exer_btn_o(set_exer_btn_i));
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // Mode per lamp: 0 off, 1 steady, 2 slow, 3 fast
   function automatic int mode(input int k);
      case (k)
         0: return util_ok_i ? 1 : 0;
         1: return util_conn_fail_i ? 2 : (util_conn_i ? 1 : 0);
         2: return (gen_volt_ok_i && gen_freq_ok_i) ? 1 : 0;
         3: return gen_conn_fail_i ? 2 : (gen_conn_i ? 1 : 0);
         default: begin
            if (!exer_enable_i) return 0;
            if (set_exer_btn_i) return 3;
            if (exer_int_active_i || (ext_exer_cfg_i && ext_exer_i)) return 2;
            return exer_sched_i ? 1 : 0;
         end
      endcase
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) begin
         @(posedge ref_clk_i);
         #1;
      end
   endtask
   // A quarter is QC cycles, so 32 cycles hold 8 or 4 toggles
   task automatic win(input int k, input int m);
      int tr;
      logic p;
      tr = 0;
      p = lamps[k];
      repeat (32) begin
         tick(1);
         if (lamps[k] !== p) tr++;
         p = lamps[k];
      end
      chk("lamp toggles", (m == 3) ? 8 : (m == 2) ? 4 : 0, tr);
      if (m < 2) chk("lamp level", m, p);
   endtask
   task automatic wait_act(input logic v);
      n = 0;
      while (test_active_o !== v && n < 300) begin
         tick(1);
         n++;
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      {rst_i, util_ok_i, gen_volt_ok_i, gen_freq_ok_i, util_conn_i, util_conn_fail_i} = 6'h30;
      {gen_conn_i, gen_conn_fail_i, exer_enable_i, exer_sched_i, exer_int_active_i} = 5'h0;
      {ext_exer_cfg_i, ext_exer_i} = 2'h0;
      repeat (3) @(posedge ref_clk_i);
      #1 rst_i = 1'b0;
      for (i = 0; i < 24; i++) begin
         r = $random(seed);
         pnl.push(2, r[12]);
         {util_ok_i, gen_volt_ok_i, gen_freq_ok_i, util_conn_i, util_conn_fail_i, gen_conn_i,
          gen_conn_fail_i, exer_enable_i, exer_sched_i, exer_int_active_i, ext_exer_cfg_i,
          ext_exer_i} = r[11:0];
         tick(2);
         for (int k = 0; k < 5; k++) begin
            win(k, mode(k));
         end
         if (util_conn_fail_i && gen_conn_fail_i)
            chk("slow phase", util_conn_lamp_o, gen_conn_lamp_o); // same rate in phase
      end
      util_ok_i = 1'b1;
      pnl.push(2, 1'b0);
      pnl.push(0, 1'b1);
      tick(2);
      win(5, 3); // start blink
      wait_act(1'b1);
      chk("button start", 1, n + 34 >= HOLD && n + 34 <= HOLD + 2); // hold window of HOLD cycles
      tick(1);
      win(5, 1); // steady in test
      pnl.push(0, 1'b0);
      pnl.push(0, 1'b1);
      tick(2);
      chk("cancel ends test", 0, test_active_o); // cancel
      win(5, 3); // cancel blink
      tick(HOLD - 30);
      win(5, 0); // off after
      pnl.push(0, 1'b0);
      pnl.push(1, 1'b1);
      wait_act(1'b1);
      chk("remote start", 1, n >= HOLD && n <= HOLD + 2); // remote start
      util_ok_i = 1'b0;
      tick(2);
      chk("power loss", 0, test_active_o); // power failed
      win(5, 0); // lamp out
      util_ok_i = 1'b1;
      pnl.push(1, 1'b0);
      pnl.push(1, 1'b1);
      wait_act(1'b1);
      pnl.push(1, 1'b0);
      tick(2);
      chk("remote release", 0, test_active_o); // test ends
      util_ok_i = 1'b0;
      pnl.push(0, 1'b1);
      tick(HOLD + 10);
      chk("start unpowered", 0, test_active_o); // normal power failed
      win(5, 0); // no blink
      util_ok_i = 1'b1;
      pnl.push(0, 1'b0);
      pnl.push(0, 1'b1);
      tick(2);
      win(5, 3); // blink while held
      pnl.push(0, 1'b0);
      tick(HOLD);
      chk("early release", 0, test_active_o); // release aborts start
      win(5, 0); // dark after abort
      tally_and_finish();
   end
endmodule

// *** include/pled_blink_if.sv ***
// Blink phase carrier from the timebase to the lamp drivers.
// Both phases come straight from timebase flip-flops.
`timescale 1ns/1ps
interface pled_blink_if;
   logic fast_ph;
   logic slow_ph;
   modport src (output fast_ph, output slow_ph);
   modport snk (input fast_ph, input slow_ph);
endinterface

// *** include/pled_defs.svh ***
// Timing constants for the front-panel lamp driver.
// Assumes a single 100 MHz system clock.
`ifndef PLED_DEFS_SVH
`define PLED_DEFS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define PLED_CLK_PERIOD_NS 10
`define PLED_NS_PER_MS 1000000
// Quarter of the slow blink period; the fast blink toggles once per quarter
`define PLED_QUARTER_MS 250
// Acknowledge and cancel blink window of the test lamp
`define PLED_TEST_HOLD_MS 2000
`define PLED_CNT_W 32

`endif

// *** include/pled_pkg.sv ***
// Types shared by the lamp driver modules.
// Assumes pled_defs.svh is on the include path.
package pled_pkg;

   // ----------------------------------------
   // Test sequence states, Gray coded
   // ----------------------------------------
   typedef enum logic [1:0] {
      PLED_T_IDLE   = 2'h0,
      PLED_T_ACK    = 2'h1,
      PLED_T_RUN    = 2'h3,
      PLED_T_CANCEL = 2'h2
   } pled_test_st_t;

   // Lamp request: fast blink beats slow blink beats steady
   typedef struct packed {
      logic fast;
      logic slow;
      logic on;
   } pled_req_t;

   function automatic logic pled_pattern(input pled_req_t req, input logic fast_ph,
                                         input logic slow_ph);
      logic lit;
      lit = 1'b0;
      if (req.fast) begin
         lit = fast_ph;
      end else if (req.slow) begin
         lit = slow_ph;
      end else if (req.on) begin
         lit = 1'b1;
      end
      return lit;
   endfunction

endpackage

// *** src/pled_lamp_drv.sv ***
// One lamp output flip-flop with pattern priority.
// Assumes requests are synchronous to ref_clk_i.
`timescale 1ns/1ps
module pled_lamp_drv
   import pled_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Blink phases
   pled_blink_if.snk blink,
   // Request and lamp
   input pled_req_t req_i,
   output logic lamp_o
);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         lamp_o <= 1'b0;
      end else begin
         lamp_o <= pled_pattern(req_i, blink.fast_ph, blink.slow_ph);
      end
   end

endmodule

// *** src/pled_status_driver.sv ***
// Front-panel status lamp driver for a transfer switch controller.
// Assumes all status inputs and buttons are debounced and synchronous.
`timescale 1ns/1ps
`include "pled_defs.svh"
module pled_status_driver
   import pled_pkg::*;
#(
   parameter int QUARTER_CYC =
      (`PLED_QUARTER_MS * `PLED_NS_PER_MS) / `PLED_CLK_PERIOD_NS,
   parameter int TEST_HOLD_CYC =
      (`PLED_TEST_HOLD_MS * `PLED_NS_PER_MS) / `PLED_CLK_PERIOD_NS
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Source sensing
   input wire logic util_ok_i,
   input wire logic gen_volt_ok_i,
   input wire logic gen_freq_ok_i,
   // Switch position and failures
   input wire logic util_conn_i,
   input wire logic util_conn_fail_i,
   input wire logic gen_conn_i,
   input wire logic gen_conn_fail_i,
   // Exercise
   input wire logic exer_enable_i,
   input wire logic exer_sched_i,
   input wire logic exer_int_active_i,
   input wire logic ext_exer_cfg_i,
   input wire logic ext_exer_i,
   input wire logic set_exer_btn_i,
   // Test
   input wire logic test_btn_i,
   input wire logic remote_test_i,
   // Lamps
   output logic util_avail_lamp_o,
   output logic util_conn_lamp_o,
   output logic gen_avail_lamp_o,
   output logic gen_conn_lamp_o,
   output logic exer_lamp_o,
   output logic test_lamp_o,
   // Test status
   output logic test_active_o
);

   localparam logic [`PLED_CNT_W-1:0] HOLD_LAST =
      TEST_HOLD_CYC[`PLED_CNT_W-1:0] - `PLED_CNT_W'h1;

   pled_blink_if blink_if ();

   // ----------------------------------------
   // Timebase
   // ----------------------------------------
   // single timebase
   pled_timebase #(
      .QUARTER_CYC(QUARTER_CYC)
   ) u_timebase (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .blink(blink_if)
   );

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   pled_test_st_t st_r;
   pled_test_st_t st_nxt;
   logic [`PLED_CNT_W-1:0] hold_cnt_r;
   logic btn_q_r;
   logic rem_q_r;
   logic src_rem_r;
   logic btn_rise;
   logic rem_rise;
   logic hold_done;
   logic src_held;

   // Level now high, low last cycle; a held input gives one pulse only
   function automatic logic rise_of(input logic now_v, input logic last_v);
      return now_v & ~last_v;
   endfunction

   assign btn_rise = rise_of(test_btn_i, btn_q_r);
   assign rem_rise = rise_of(remote_test_i, rem_q_r);
   assign hold_done = (hold_cnt_r == HOLD_LAST);
   assign src_held = src_rem_r ? remote_test_i : test_btn_i;

   // ----------------------------------------
   // Input sampling
   // ----------------------------------------
   // Both inputs idle low, so no false edge follows reset
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         btn_q_r <= 1'b0;
         rem_q_r <= 1'b0;
      end else begin
         btn_q_r <= test_btn_i;
         rem_q_r <= remote_test_i;
      end
   end

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         PLED_T_IDLE: begin
            if (util_ok_i && (btn_rise || rem_rise)) begin
               st_nxt = PLED_T_ACK;
            end
         end
         PLED_T_ACK: begin
            // Starting input must be held the whole window; early release aborts
            if (!util_ok_i || !src_held) begin
               st_nxt = PLED_T_IDLE;
            end else if (hold_done) begin
               st_nxt = PLED_T_RUN;
            end
         end
         PLED_T_RUN: begin
            if (!util_ok_i || (src_rem_r && !remote_test_i)) begin
               st_nxt = PLED_T_IDLE;
            end else if (btn_rise) begin
               st_nxt = PLED_T_CANCEL;
            end
         end
         PLED_T_CANCEL: begin
            if (hold_done) begin
               st_nxt = PLED_T_IDLE;
            end
         end
         default: begin
            st_nxt = PLED_T_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Unknown codes fall back to IDLE through the default branch
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_r <= PLED_T_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Counter restarts on every state change; only ACK and CANCEL read it
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         hold_cnt_r <= `PLED_CNT_W'h0;
      end else if (st_nxt != st_r) begin
         hold_cnt_r <= `PLED_CNT_W'h0;
      end else begin
         hold_cnt_r <= hold_cnt_r + `PLED_CNT_W'h1;
      end
   end

   // Button wins when both start in one cycle
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         src_rem_r <= 1'b0;
      end else if (st_r == PLED_T_IDLE && st_nxt == PLED_T_ACK) begin
         src_rem_r <= ~btn_rise;
      end
   end

   // ----------------------------------------
   // Test status output
   // ----------------------------------------
   // Taken from the next state so flag and state change together
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         test_active_o <= 1'b0;
      end else begin
         test_active_o <= (st_nxt == PLED_T_RUN);
      end
   end

   // ----------------------------------------
   // Lamp requests
   // ----------------------------------------
   pled_req_t util_av_req;
   pled_req_t util_cn_req;
   pled_req_t gen_av_req;
   pled_req_t gen_cn_req;
   pled_req_t exer_req;
   pled_req_t test_req;
   logic exer_running;

   assign exer_running = exer_int_active_i | (ext_exer_cfg_i & ext_exer_i);

   always_comb begin
      util_av_req = '{fast: 1'b0, slow: 1'b0, on: util_ok_i};
   end

   // utility connection
   // Failure flag is a level held by the sequencer, so nothing is latched here
   always_comb begin
      util_cn_req = '{fast: 1'b0, slow: util_conn_fail_i, on: util_conn_i};
   end

   always_comb begin
      gen_av_req = '{fast: 1'b0, slow: 1'b0, on: gen_volt_ok_i & gen_freq_ok_i};
   end

   always_comb begin
      gen_cn_req = '{fast: 1'b0, slow: gen_conn_fail_i, on: gen_conn_i};
   end

   always_comb begin
      exer_req = '{fast: exer_enable_i & set_exer_btn_i,
                   slow: exer_enable_i & exer_running,
                   on: exer_enable_i & exer_sched_i};
   end

   // steady while running
   // Lamp lags the state by one clock, so it goes dark a cycle after IDLE
   always_comb begin
      test_req = '{fast: (st_r == PLED_T_ACK) || (st_r == PLED_T_CANCEL),
                   slow: 1'b0,
                   on: st_r == PLED_T_RUN};
   end

   // ----------------------------------------
   // Lamp outputs
   // ----------------------------------------
   // priority in each driver
   pled_lamp_drv u_util_av (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .blink(blink_if),
      .req_i(util_av_req),
      .lamp_o(util_avail_lamp_o)
   );

   pled_lamp_drv u_util_cn (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .blink(blink_if),
      .req_i(util_cn_req),
      .lamp_o(util_conn_lamp_o)
   );

   pled_lamp_drv u_gen_av (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .blink(blink_if),
      .req_i(gen_av_req),
      .lamp_o(gen_avail_lamp_o)
   );

   pled_lamp_drv u_gen_cn (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .blink(blink_if),
      .req_i(gen_cn_req),
      .lamp_o(gen_conn_lamp_o)
   );

   pled_lamp_drv u_exer (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .blink(blink_if),
      .req_i(exer_req),
      .lamp_o(exer_lamp_o)
   );

   pled_lamp_drv u_test (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .blink(blink_if),
      .req_i(test_req),
      .lamp_o(test_lamp_o)
   );

endmodule

// *** src/pled_timebase.sv ***
// Shared blink timebase: one counter, both rates in phase.
// Assumes QUARTER_CYC is at least 2.
`timescale 1ns/1ps
`include "pled_defs.svh"
module pled_timebase
   import pled_pkg::*;
#(
   parameter int QUARTER_CYC = 25000000
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Phases out
   pled_blink_if.src blink
);

   logic [`PLED_CNT_W-1:0] cnt_r;
   logic [1:0] phase_r;
   logic wrap;

   assign wrap = (cnt_r == QUARTER_CYC[`PLED_CNT_W-1:0] - `PLED_CNT_W'h1);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt_r <= `PLED_CNT_W'h0;
      end else if (wrap) begin
         cnt_r <= `PLED_CNT_W'h0;
      end else begin
         cnt_r <= cnt_r + `PLED_CNT_W'h1;
      end
   end

   // ----------------------------------------
   // Phase counter
   // ----------------------------------------
   // one divided source
   // Fast is bit 0, slow bit 1, so every slow edge lines up with a fast edge
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         phase_r <= 2'h0;
      end else if (wrap) begin
         phase_r <= phase_r + 2'h1;
      end
   end

   assign blink.fast_ph = phase_r[0];
   assign blink.slow_ph = phase_r[1];

endmodule
